/* test/flpc_host_model.sv */
// Host controller model driving the serial flash pins
`timescale 1ns/10ps
module flpc_host_model (
    input wire logic core_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    // Half link period, 80 ns at 5 ns per cycle
    localparam int HALF = 16;
    logic [7:0] txb [64];
    logic so_seen;
    logic so_bits [512];
    int so_err;
    int hi_cnt;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        so_seen = 1'b0;
        so_err = 0;
        hi_cnt = 0;
    end

    // Junk on si while deselected, must be ignored
    always @(negedge core_clk) begin
        if (cs_n) begin
            si <= ~si;
        end
    end

    // so steady while sck high; released when deselected
    always @(posedge core_clk) begin
        hi_cnt <= cs_n ? hi_cnt + 1 : 0;
        if (!cs_n && sck && so !== so_seen) begin
            so_err <= so_err + 1;
        end
        if (hi_cnt > 6 && so_oe !== 1'b0) begin
            so_err <= so_err + 1;
        end
    end

    // framed bytes, MSB first, clock idle outside frame
    task automatic frame(input int nbytes, input int xbits);
        @(negedge core_clk);
        cs_n = 1'b0;
        repeat (HALF) @(negedge core_clk);
        for (int i = 0; i < nbytes * 8 + xbits; i++) begin
            si = txb[i / 8][7 - i % 8];
            repeat (HALF) @(negedge core_clk);
            sck = 1'b1;
            so_seen = so;
            so_bits[i] = so;
            repeat (HALF) @(negedge core_clk);
            sck = 1'b0;
        end
        repeat (HALF) @(negedge core_clk);
        cs_n = 1'b1;
        repeat (HALF) @(negedge core_clk);
    endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the serial flash pin control block
`timescale 1ns/10ps
module testbench;
    import flpc_pkg::*;
    localparam int PE_N = 400;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sck, si, so, so_oe, tx_load, opcode_valid;
    logic wp_n = 1'b1, wp_float = 1'b0, reset_n = 1'b1;
    logic [7:0] tx_byte = 8'h00;
    flpc_kind_t op_kind = FLPC_OP_NONE;
    logic sector_prot = 1'b0, sw_prot_en = 1'b0, rx_ready = 1'b0;
    logic rx_valid, rx_overrun, op_start, op_end, pe_launch, map_write;
    logic prot_cmd_ok, reject, busy, standby;
    logic [7:0] opcode, rx_data;
    int err_total = 0, compares = 0;
    int n_launch, n_map, n_ok, n_rej, n_start, n_end;
    int busy_len = 0, busy_run = 0;
    bit drain = 1'b0;
    logic [7:0] rxq [$];
    logic [7:0] txq [$];
    // Pull-up on the protect pin when left floating
    tri1 wp_pin;
    assign wp_pin = wp_float ? 1'bz : wp_n;

    always #2.5 core_clk = ~core_clk;

    flpc_top #(.PE_CYCLES(PE_N), .FIFO_DEPTH(32)) uut (
        .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_pin), .reset_n(reset_n), .so(so), .so_oe(so_oe),
        .tx_byte(tx_byte), .tx_load(tx_load), .op_kind(op_kind),
        .sector_prot(sector_prot), .sw_prot_en(sw_prot_en),
        .opcode(opcode), .opcode_valid(opcode_valid), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
        .op_start(op_start), .op_end(op_end), .pe_launch(pe_launch),
        .map_write(map_write), .prot_cmd_ok(prot_cmd_ok), .reject(reject),
        .busy(busy), .standby(standby)
    );

    flpc_host_model host (
        .core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe(so_oe)
    );

    // Pulse counters, busy length and received bytes
    always @(posedge core_clk) begin
        if (pe_launch === 1'b1) n_launch++;
        if (map_write === 1'b1) n_map++;
        if (prot_cmd_ok === 1'b1) n_ok++;
        if (reject === 1'b1) n_rej++;
        if (op_start === 1'b1) n_start++;
        if (op_end === 1'b1) n_end++;
        if (busy === 1'b1) busy_run++;
        else if (busy_run > 0) begin
            busy_len = busy_run;
            busy_run = 0;
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
        if (tx_load === 1'b1) txq.push_back(tx_byte);
    end

    // Random consumer stalls and transmit bytes, off the sampling edge
    always @(negedge core_clk) begin
        rx_ready <= drain & 1'($urandom);
        tx_byte <= 8'($urandom);
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic run(input int n, input int xb);
        {n_launch, n_map, n_ok, n_rej, n_start, n_end} = '0;
        rxq.delete();
        txq.delete();
        host.frame(n, xb);
        repeat (8) @(negedge core_clk);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 1000 && standby !== 1'b1; i++)
            @(negedge core_clk);
        // One more edge so the busy length is recorded
        @(negedge core_clk);
    endtask

    // Expected {launch, map, ok, reject} as weighted counts
    function automatic int decide(input flpc_kind_t k, input logic w,
                                  input logic sp, input logic sw,
                                  input logic bz);
        case (k)
            FLPC_OP_MODIFY: return ((sp && (!w || sw)) || bz) ? 1 : 8;
            FLPC_OP_MAP_WR: return !w ? 1 : 4;
            FLPC_OP_LOCK: return 2;
            default: return 0;
        endcase
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog, well beyond the expected run of some 24k cycles
    initial begin
        #400_000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        int n;
        int exp;
        int k;
        void'($urandom(32'h8a31));
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("standby", 1, standby);
        chk("so_oe", 0, so_oe);
        $display("test reset done");
        drain = 1'b1;
        for (int t = 0; t < 6; t++) begin
            n = 1 + $urandom % 3;
            for (int b = 0; b < n; b++) host.txb[b] = 8'($urandom);
            if (t == 0) host.txb[0] = 8'h80;
            run(n, 0);
            chk("op_start", 1, n_start);
            chk("op_end", 1, n_end);
            chk("opcode", host.txb[0], opcode);
            chk("opcode valid", 1, opcode_valid);
            chk("rx count", n, rxq.size());
            for (int b = 0; b < n; b++)
                chk("rx byte", host.txb[b], rxq[b]);
            // First rise sees no loaded bit yet, so start at one
            for (int i = 1; i < n * 8; i++) begin
                k = i - 1;
                chk("so bit", txq[k/8][7-k%8], host.so_bits[i]);
            end
        end
        $display("test random frames done");
        host.txb[0] = 8'ha5;
        host.txb[1] = 8'hff;
        run(1, 3);
        chk("partial count", 1, rxq.size());
        host.txb[0] = 8'h3c;
        run(1, 0);
        chk("realigned opcode", 8'h3c, opcode);
        $display("test partial byte done");
        for (int c = 0; c < 24; c++) begin
            op_kind = flpc_kind_t'(1 + c / 8);
            wp_n = c[0];
            wp_float = c[0] & c[1];
            sector_prot = c[1];
            sw_prot_en = c[2];
            exp = decide(op_kind, c[0], c[1], c[2], 1'b0);
            host.txb[0] = 8'($urandom);
            run(1, 0);
            n = n_launch * 8 + n_map * 4 + n_ok * 2 + n_rej;
            chk("decision", exp, n);
            if (exp == 8) begin
                chk("standby busy", 0, standby);
                wait_idle();
                chk("busy length", PE_N, busy_len);
            end
        end
        $display("test protection table done");
        op_kind = FLPC_OP_MODIFY;
        {wp_float, sector_prot, sw_prot_en} = 3'h0;
        wp_n = 1'b1;
        run(1, 0);
        run(1, 0);
        chk("modify while busy", decide(op_kind, 1, 0, 0, 1),
            n_launch * 8 + n_rej);
        reset_n = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("busy after reset pin", 0, busy);
        chk("opcode valid held", 0, opcode_valid);
        run(1, 0);
        chk("held launch", 0, n_launch);
        chk("held rx", 0, rxq.size());
        reset_n = 1'b1;
        repeat (8) @(negedge core_clk);
        op_kind = FLPC_OP_NONE;
        host.txb[0] = 8'h5a;
        run(1, 0);
        chk("resumed opcode", 8'h5a, opcode);
        $display("test busy and reset pin done");
        drain = 1'b0;
        for (int b = 0; b < 34; b++) host.txb[b] = 8'($urandom);
        run(34, 0);
        chk("overrun", 1, rx_overrun);
        drain = 1'b1;
        repeat (300) @(negedge core_clk);
        chk("fifo held", 33, rxq.size());
        chk("fifo first", host.txb[0], rxq[0]);
        chk("fifo last", host.txb[32], rxq[32]);
        chk("so timing", 0, host.so_err);
        $display("test fifo fill done");
        tally_and_finish();
    end
endmodule

/* verilog/flpc_fifo.sv */
// Received byte FIFO with registered read data
`timescale 1ns/10ps
module flpc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    flpc_stream_if.snk in_if,
    flpc_stream_if.src out_if
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic [W-1:0] dout_r, dout_nxt;
    logic dval_r, dval_nxt;
    logic push, load;

    // Full counts only the array; the output register adds one slot
    assign in_if.ready = (cnt_r != DEPTH[AW:0]);
    assign push = in_if.valid && in_if.ready;
    assign load = (cnt_r != '0) && (!dval_r || out_if.ready);
    assign out_if.valid = dval_r;
    assign out_if.data = dout_r;

    // Pointer, count and output stage next values
    always_comb begin
        wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt = load ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (push && !load) begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end else if (load && !push) begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
        dout_nxt = load ? mem[rd_r] : dout_r;
        if (load) begin
            dval_nxt = 1'b1;
        end else if (out_if.ready) begin
            dval_nxt = 1'b0;
        end else begin
            dval_nxt = dval_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            dout_r <= '0;
            dval_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            dout_r <= dout_nxt;
            dval_r <= dval_nxt;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_r] <= in_if.data;
        end
    end
endmodule

/* verilog/flpc_pkg.sv */
// Constants and types for the serial flash pin control block
// Overview of operation
// - Deselected: standby, serial output released
// - Deselected: serial input bits are ignored
// - Chip select falling edge starts operation
// - Chip select rising edge ends operation
// - No standby until self-timed cycle ends
// - Input bits sampled on clock rising edge
// - Output bits change on clock falling edge
// - Program and erase are internally timed
// - Protect pin low blocks mapped sectors
// - Pin protection independent of software protection
// - Protect pin low freezes protection map
// - Blocked modify does nothing, idles at end
// - Protect enable and lock still accepted
// - Floating protect pin reads as unprotected
// - Reset pin low aborts, forces idle
// - Held in reset while pin low
// - Power-on reset initialises the device
// - First byte after select is opcode
// - All bytes travel most significant first
package flpc_pkg;
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_MHZ = 200;
    // Self-timed program or erase duration, nanoseconds
    localparam int PE_TIME_NS = 5000;
    localparam int PE_CYCLES = (PE_TIME_NS * CLK_MHZ) / 1000;
    localparam int PE_CNT_W = 16;
    // Synchroniser bit positions
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_WP = 3;
    localparam int PIN_RST = 4;
    localparam int PIN_N = 5;
    // Idle levels: select high, protect high, reset high
    localparam logic [4:0] PIN_IDLE = 5'h19;
    localparam logic [1:0] BYTE_CNT_MAX = 2'h3;

    typedef enum logic [1:0] {
        FLPC_IDLE = 2'h1,
        FLPC_SEL = 2'h2
    } flpc_state_t;

    typedef enum logic [1:0] {
        FLPC_OP_NONE = 2'h0,
        FLPC_OP_MODIFY = 2'h1,
        FLPC_OP_MAP_WR = 2'h2,
        FLPC_OP_LOCK = 2'h3
    } flpc_kind_t;
endpackage

/* verilog/flpc_stream_if.sv */
// Byte stream carrier between the pin logic and its buffer
`timescale 1ns/10ps
interface flpc_stream_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* verilog/flpc_top.sv */
// Serial flash pin control: framing, shifting, protection, reset
`timescale 1ns/10ps
module flpc_top #(
    parameter int PE_CYCLES = flpc_pkg::PE_CYCLES,
    parameter int FIFO_DEPTH = flpc_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    input wire logic reset_n,
    output logic so,
    output logic so_oe,
    input wire logic [flpc_pkg::BYTE_W-1:0] tx_byte,
    output logic tx_load,
    input wire flpc_pkg::flpc_kind_t op_kind,
    input wire logic sector_prot,
    input wire logic sw_prot_en,
    output logic [flpc_pkg::BYTE_W-1:0] opcode,
    output logic opcode_valid,
    output logic [flpc_pkg::BYTE_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic op_start,
    output logic op_end,
    output logic pe_launch,
    output logic map_write,
    output logic prot_cmd_ok,
    output logic reject,
    output logic busy,
    output logic standby
);
    import flpc_pkg::*;

    logic [PIN_N-1:0] pin_meta_r, pin_sync_r;
    logic cs_s, sck_s, si_s, wp_s, rstpin_s, pin_rst;
    logic cs_d_r, sck_d_r;
    logic cs_fall, cs_rise, sck_rise, sck_fall;
    flpc_state_t state_r, state_nxt;
    logic [2:0] bit_r, bit_nxt, tbit_r, tbit_nxt;
    logic [1:0] byte_r, byte_nxt;
    logic [BYTE_W-1:0] sh_r, sh_nxt, tsh_r, tsh_nxt;
    logic [BYTE_W-1:0] opc_r, opc_nxt;
    logic opv_r, opv_nxt, so_r, so_nxt, ovr_r, ovr_nxt;
    logic [PE_CNT_W-1:0] pe_r, pe_nxt;
    logic push, blocked;
    logic [PIN_N-1:0] pin_raw;

    flpc_stream_if #(.W(BYTE_W)) push_if ();
    flpc_stream_if #(.W(BYTE_W)) pop_if ();

    // Pins gathered in synchroniser bit order
    assign pin_raw = {reset_n, wp_n, si, sck, cs_n};

    // Two-stage synchronisers; idle levels keep protect high at reset
    // pull-up reading
    genvar g;
    for (g = 0; g < PIN_N; g++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (rst) begin
                pin_meta_r[g] <= PIN_IDLE[g];
                pin_sync_r[g] <= PIN_IDLE[g];
            end else begin
                pin_meta_r[g] <= pin_raw[g];
                pin_sync_r[g] <= pin_meta_r[g];
            end
        end
    end

    assign cs_s = pin_sync_r[PIN_CS];
    assign sck_s = pin_sync_r[PIN_SCK];
    assign si_s = pin_sync_r[PIN_SI];
    assign wp_s = pin_sync_r[PIN_WP];
    assign rstpin_s = pin_sync_r[PIN_RST];
    assign pin_rst = !rstpin_s;

    // Edge finders on the synchronised levels
    assign cs_fall = cs_d_r && !cs_s;
    assign cs_rise = !cs_d_r && cs_s;
    assign sck_rise = !sck_d_r && sck_s;
    assign sck_fall = sck_d_r && !sck_s;

    assign blocked = sector_prot && (!wp_s || sw_prot_en);

    // Framing, shifting and protection decisions
    always_comb begin
        state_nxt = state_r;
        bit_nxt = bit_r;
        tbit_nxt = tbit_r;
        byte_nxt = byte_r;
        sh_nxt = sh_r;
        tsh_nxt = tsh_r;
        opc_nxt = opc_r;
        opv_nxt = opv_r;
        so_nxt = so_r;
        ovr_nxt = ovr_r;
        pe_nxt = (pe_r != '0) ? PE_CNT_W'(pe_r - 1'b1) : pe_r;
        push = 1'b0;
        tx_load = 1'b0;
        op_start = 1'b0;
        op_end = 1'b0;
        pe_launch = 1'b0;
        map_write = 1'b0;
        prot_cmd_ok = 1'b0;
        reject = 1'b0;
        if (pin_rst) begin
            state_nxt = FLPC_IDLE;
            bit_nxt = '0;
            tbit_nxt = '0;
            byte_nxt = '0;
            opv_nxt = 1'b0;
            so_nxt = 1'b0;
            pe_nxt = '0;
        end else begin
            unique case (state_r)
                FLPC_IDLE: begin
                    if (cs_fall) begin
                        state_nxt = FLPC_SEL;
                        bit_nxt = '0;
                        tbit_nxt = '0;
                        byte_nxt = '0;
                        opv_nxt = 1'b0;
                        ovr_nxt = 1'b0;
                        op_start = 1'b1;
                    end
                end
                FLPC_SEL: begin
                    if (cs_rise) begin
                        state_nxt = FLPC_IDLE;
                        op_end = 1'b1;
                        unique case (op_kind)
                            FLPC_OP_MODIFY: begin
                                if (blocked || pe_r != '0) begin
                                    reject = 1'b1;
                                end else begin
                                    pe_launch = 1'b1;
                                    pe_nxt = PE_CNT_W'(PE_CYCLES);
                                end
                            end
                            FLPC_OP_MAP_WR: begin
                                reject = !wp_s;
                                map_write = wp_s;
                            end
                            FLPC_OP_LOCK: begin
                                prot_cmd_ok = 1'b1;
                            end
                            FLPC_OP_NONE: begin
                            end
                        endcase
                    end else if (sck_rise) begin
                        // first bit is the top bit
                        sh_nxt = {sh_r[BYTE_W-2:0], si_s};
                        bit_nxt = 3'(bit_r + 1'b1);
                        if (bit_r == BIT_LAST) begin
                            if (byte_r == '0) begin
                                opc_nxt = {sh_r[BYTE_W-2:0], si_s};
                                opv_nxt = 1'b1;
                            end
                            if (byte_r != BYTE_CNT_MAX) begin
                                byte_nxt = 2'(byte_r + 1'b1);
                            end
                            push = 1'b1;
                            // Link cannot pause, so a full buffer drops
                            ovr_nxt = ovr_r || !push_if.ready;
                        end
                    end else if (sck_fall) begin
                        tbit_nxt = 3'(tbit_r + 1'b1);
                        if (tbit_r == '0) begin
                            tx_load = 1'b1;
                            so_nxt = tx_byte[BYTE_W-1];
                            tsh_nxt = {tx_byte[BYTE_W-2:0], 1'b0};
                        end else begin
                            so_nxt = tsh_r[BYTE_W-1];
                            tsh_nxt = {tsh_r[BYTE_W-2:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    // core reset stands in for power-on reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_d_r <= 1'b1;
            sck_d_r <= 1'b0;
            state_r <= FLPC_IDLE;
            bit_r <= '0;
            tbit_r <= '0;
            byte_r <= '0;
            sh_r <= '0;
            tsh_r <= '0;
            opc_r <= '0;
            opv_r <= 1'b0;
            so_r <= 1'b0;
            ovr_r <= 1'b0;
            pe_r <= '0;
        end else begin
            cs_d_r <= cs_s;
            sck_d_r <= sck_s;
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            tbit_r <= tbit_nxt;
            byte_r <= byte_nxt;
            sh_r <= sh_nxt;
            tsh_r <= tsh_nxt;
            opc_r <= opc_nxt;
            opv_r <= opv_nxt;
            so_r <= so_nxt;
            ovr_r <= ovr_nxt;
            pe_r <= pe_nxt;
        end
    end

    // Received bytes into the buffer
    assign push_if.valid = push;
    assign push_if.data = sh_nxt;

    flpc_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_if(push_if),
        .out_if(pop_if)
    );

    assign rx_data = pop_if.data;
    assign rx_valid = pop_if.valid;
    assign pop_if.ready = rx_ready;

    // Output drive only while selected
    // output released when deselected
    assign so = so_r;
    assign so_oe = (state_r == FLPC_SEL);
    assign opcode = opc_r;
    assign opcode_valid = opv_r;
    assign rx_overrun = ovr_r;
    assign busy = (pe_r != '0);
    assign standby = (state_r == FLPC_IDLE) && (pe_r == '0);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_oe_released: assert property (
        state_r == FLPC_SEL && cs_rise |=> !so_oe
    ) else $error("serial output still driven after deselect");
    a_idle_no_push: assert property (
        state_r == FLPC_IDLE |-> !push_if.valid && !tx_load
    ) else $error("byte accepted while deselected");
    a_frame_start: assert property (
        state_r == FLPC_IDLE && cs_fall && !pin_rst
            |=> state_r == FLPC_SEL && bit_r == '0 && byte_r == '0
    ) else $error("frame did not start on select fall");
    a_frame_end: assert property (
        state_r == FLPC_SEL && cs_rise && !pin_rst
            |-> op_end ##1 state_r == FLPC_IDLE
    ) else $error("frame did not end on select rise");
    a_busy_no_idle: assert property (
        busy |-> !standby
    ) else $error("standby entered during timed cycle");
    a_rise_sample: assert property (
        state_r == FLPC_SEL && sck_rise && !cs_rise && !pin_rst
            |=> sh_r[0] == $past(si_s)
    ) else $error("input bit not sampled on rising edge");
    a_fall_drive: assert property (
        $changed(so_r) |-> $past(sck_fall) || $past(pin_rst)
    ) else $error("output changed away from falling edge");
    a_timer_runs: assert property (
        pe_launch && !pin_rst |=> busy [*8]
    ) else $error("timed cycle ended too early");
    a_pin_blocks: assert property (
        state_r == FLPC_SEL && cs_rise && !pin_rst
            && op_kind == FLPC_OP_MODIFY && sector_prot && !wp_s
            |-> reject && !pe_launch ##1 state_r == FLPC_IDLE
    ) else $error("protected sector modified under pin protect");
    a_soft_blocks: assert property (
        state_r == FLPC_SEL && cs_rise && !pin_rst && wp_s
            && op_kind == FLPC_OP_MODIFY && sector_prot && sw_prot_en
            |-> reject && !pe_launch
    ) else $error("software protection not enforced");
    a_map_frozen: assert property (
        state_r == FLPC_SEL && cs_rise && !pin_rst
            && op_kind == FLPC_OP_MAP_WR && !wp_s |-> reject && !map_write
    ) else $error("protection map written with pin low");
    a_lock_taken: assert property (
        state_r == FLPC_SEL && cs_rise && !pin_rst
            && op_kind == FLPC_OP_LOCK |-> prot_cmd_ok
    ) else $error("lock command refused");
    a_pin_reset: assert property (
        pin_rst |=> state_r == FLPC_IDLE && !busy && !so_oe
    ) else $error("reset pin did not force idle");

    c_frame: cover property (op_start ##[1:1000] op_end);
    c_launch: cover property (pe_launch ##[1:1000] !busy);
    c_reject: cover property (reject);
    c_overrun: cover property (rx_overrun);
endmodule
